/* rtl/lineout_level_ctrl.sv */
// Added by the designer: the placing of the registers and the APB slave port.
`timescale 1ns/1ns
// Functional notes
// - Enable regulates gain; disabled holds 0dB.
// - Threshold crossing cuts gain immediately.
// - Threshold select picks limit and band.
// - Step code cuts one to four steps.
// - Limiter period from code, rate-scaled.
// - Quiet wait raises gain, capped at reference.
// - Recovery period from code, rate-scaled.
// - Recovery step is one or two steps.
// - Reference code linear, default +18dB.
// - Increases ramp unless soft ramp disabled.
// - Threshold during recovery restarts limiting.
// - Band clears wait timer; below runs it.
// - Gain starts at 0dB on enable.
// - Attenuation code and mute for line out.
// - Bass boost select shared by both channels.
// - Boost corner scales with sample rate.
// - Input buffers powered by any output power.
// - Transition time code sets ramp time.
module lineout_level_ctrl
  import lineout_alc_pkg::*;
(
  input  wire logic              sys_clk,          // 250 MHz clock
  input  wire logic              nrst,             // Sync reset, low
  input  wire logic              psel,             // APB select
  input  wire logic              penable,          // APB enable
  input  wire logic              pwrite,           // APB write
  input  wire logic [7:0]        paddr,            // APB byte address
  input  wire logic [31:0]       pwdata,           // APB write data
  output logic      [31:0]       prdata,           // APB read data
  output logic                   pready,           // APB ready
  output logic                   pslverr,          // APB error
  input  wire logic              fs_tick,          // One pulse per fs
  input  wire logic signed [7:0] left_level,       // Left out level
  input  wire logic signed [7:0] right_level,      // Right out level
  output logic      [5:0]        alc_gain,         // Applied gain code
  output logic      [3:0]        line_out_atten,   // Volume code
  output logic                   line_out_muted,   // Line out muted
  output logic      [1:0]        bass_boost_sel,   // Boost, both ch
  output logic                   input_buf_power   // Input buffers on
);
  logic [31:0] ctrl_q;
  logic [31:0] cfg_q;
  logic [31:0] vol_q;
  logic        pready_q;
  logic        pslverr_q;
  logic [31:0] prdata_q;
  alc_state_t  st_q;
  logic [5:0]  gain_q;
  logic [5:0]  gain_out_q;
  logic        access;
  logic        wr_en;
  logic        addr_ok;
  logic [31:0] rd_mux;
  logic [3:0]  scale;

  period_timer_if lim_t ();
  period_timer_if wait_t ();
  period_timer_if ramp_t ();

  period_timer u_lim (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .t       (lim_t)
  );
  period_timer u_wait (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .t       (wait_t)
  );
  period_timer u_ramp (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .t       (ramp_t)
  );

  // APB: one wait state so read data comes from a flop
  assign access = psel && penable;
  assign wr_en  = access && pready_q && pwrite && addr_ok;
  assign addr_ok = (paddr == ADDR_CTRL) || (paddr == ADDR_CFG) ||
                   (paddr == ADDR_VOL)  || (paddr == ADDR_STAT);

  always_comb begin
    rd_mux = '0;
    unique case (paddr)
      ADDR_CTRL: rd_mux = ctrl_q;
      ADDR_CFG:  rd_mux = cfg_q;
      ADDR_VOL:  rd_mux = vol_q;
      ADDR_STAT: begin
        rd_mux[5:0]               = gain_out_q;
        rd_mux[STAT_TGT +: 6]     = gain_q;
        rd_mux[STAT_ST +: 2]      = st_q;
        rd_mux[STAT_BAD]          = (scale == '0);
      end
      default:   rd_mux = '0;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= '0;
    end else begin
      pready_q  <= access && !pready_q;
      pslverr_q <= access && !pready_q && !addr_ok;
      if (access && !pready_q) begin
        prdata_q <= pwrite ? '0 : rd_mux;
      end
    end
  end

  assign pready  = pready_q;
  assign pslverr = pslverr_q;
  assign prdata  = prdata_q;

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      ctrl_q <= CTRL_RST;
      cfg_q  <= CFG_RST;
      vol_q  <= VOL_RST;
    end else if (wr_en) begin
      if (paddr == ADDR_CTRL) ctrl_q <= pwdata & CTRL_MASK;
      if (paddr == ADDR_CFG)  cfg_q  <= pwdata & CFG_MASK;
      if (paddr == ADDR_VOL)  vol_q  <= pwdata & VOL_MASK;
    end
  end

  // Field views
  logic        en;
  logic        ramp_dis;
  logic [5:0]  ref_lvl;
  logic [2:0]  att_steps;
  logic [2:0]  rec_steps;
  logic [1:0]  wait_sel;
  logic [1:0]  pts_sel;
  logic [1:0]  lim_sel;

  assign en        = ctrl_q[CTRL_EN];
  assign ramp_dis  = ctrl_q[CTRL_RAMPD];
  assign scale     = rate_scale(ctrl_q[CTRL_RATE +: 4]);
  assign ref_lvl   = cfg_q[CFG_REF +: 6];
  assign att_steps = {1'b0, cfg_q[CFG_ATT +: 2]} + 3'd1;
  assign rec_steps = cfg_q[CFG_RGAIN] ? 3'd2 : 3'd1;
  assign wait_sel  = cfg_q[CFG_WAIT +: 2];
  assign pts_sel   = cfg_q[CFG_PTS +: 2];
  assign lim_sel   = cfg_q[CFG_LIMP +: 2];

  // Period targets in half-fs units: base * scale * 2 / 12
  logic [18:0] lim_base;
  logic [18:0] wait_base;
  logic [18:0] ramp_base;
  logic [22:0] lim_prod;
  logic [22:0] wait_prod;
  logic [22:0] ramp_prod;

  assign lim_base  = LIM_BASE << lim_sel;
  assign wait_base = (wait_sel == 2'b11) ? WAIT_LONG
                                         : (WAIT_BASE << wait_sel);
  assign ramp_base = RAMP_BASE << pts_sel;
  assign lim_prod  = 23'(lim_base * scale) / 23'(SCALE_DEN);
  assign wait_prod = 23'(wait_base * scale) / 23'(SCALE_DEN);
  assign ramp_prod = 23'(ramp_base * scale) / 23'(SCALE_DEN);

  // Level detect on the louder channel
  logic signed [7:0] peak;
  logic signed [7:0] lim_thr;
  logic signed [7:0] band_thr;
  logic              over;
  logic              in_band;

  assign peak     = (left_level > right_level) ? left_level : right_level;
  assign lim_thr  = cfg_q[CFG_THR] ? LIM_LO  : LIM_HI;
  assign band_thr = cfg_q[CFG_THR] ? BAND_LO : BAND_HI;
  assign over     = fs_tick && (peak >= lim_thr);
  assign in_band  = fs_tick && (peak >= band_thr) && (peak < lim_thr);

  // Limiter decisions
  logic       cut;
  logic       rec_step;
  logic [5:0] gain_cut;
  logic [6:0] gain_sum;
  logic [5:0] gain_rec;

  assign cut = over && ((st_q == ST_RECOVER) ||
               ((st_q == ST_LIMIT) && lim_t.done));
  assign rec_step = (st_q == ST_RECOVER) && wait_t.done && !over;
  assign gain_cut = (gain_q < 6'(att_steps)) ? GAIN_MIN
                                             : gain_q - 6'(att_steps);
  assign gain_sum = {1'b0, gain_q} + 7'(rec_steps);
  assign gain_rec = (gain_q >= ref_lvl) ? gain_q :
                    (gain_sum > {1'b0, ref_lvl}) ? ref_lvl
                                                 : gain_sum[5:0];

  assign lim_t.tick    = fs_tick;
  assign lim_t.target  = lim_prod[16:0];
  assign lim_t.clear   = cut || (st_q != ST_LIMIT);
  assign wait_t.tick   = fs_tick;
  assign wait_t.target = wait_prod[16:0];
  // Band keeps timer at zero; below band it runs
  assign wait_t.clear  = (st_q != ST_RECOVER) || in_band ||
                         over || rec_step;
  assign ramp_t.tick   = fs_tick;
  // Two-step raise spreads over the same time at half spacing
  assign ramp_t.target = rec_steps[1] ? (ramp_prod[16:0] >> 1)
                                      : ramp_prod[16:0];
  assign ramp_t.clear  = (gain_out_q >= gain_q) || ramp_t.done;

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      st_q <= ST_OFF;
    end else if (!en) begin
      st_q <= ST_OFF;
    end else begin
      unique case (st_q)
        ST_OFF:     st_q <= ST_RECOVER;
        ST_LIMIT:   if (fs_tick && lim_t.done && !over) st_q <= ST_RECOVER;
        ST_RECOVER: if (cut) st_q <= ST_LIMIT;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      gain_q <= GAIN_0DB;
    end else if (!en || st_q == ST_OFF) begin
      gain_q <= GAIN_0DB;
    end else if (cut) begin
      gain_q <= gain_cut;
    end else if (rec_step) begin
      gain_q <= gain_rec;
    end
  end

  // Cuts apply at once; raises ramp one code per interval
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      gain_out_q <= GAIN_0DB;
    end else if (!en || st_q == ST_OFF) begin
      gain_out_q <= GAIN_0DB;
    end else if (ramp_dis || gain_q < gain_out_q) begin
      gain_out_q <= gain_q;
    end else if (gain_q > gain_out_q && ramp_t.done) begin
      gain_out_q <= gain_out_q + 6'd1;
    end
  end

  assign alc_gain = gain_out_q;

  // Boost coefficients depend on code only, so the corner
  // follows fs without any rate term
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      line_out_atten  <= '0;
      line_out_muted  <= 1'b1;
      bass_boost_sel  <= '0;
      input_buf_power <= 1'b0;
    end else begin
      line_out_atten  <= vol_q[VOL_ATT +: 4];
      line_out_muted  <= ctrl_q[CTRL_MUTE];
      bass_boost_sel  <= ctrl_q[CTRL_BASS +: 2];
      input_buf_power <= ctrl_q[CTRL_LOPWR] ||
                         ctrl_q[CTRL_HPLPW] ||
                         ctrl_q[CTRL_HPRPW];
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  sequence s_held_off;
    !en ##1 !en;
  endsequence

  a_off_gain: assert property (s_held_off |-> gain_out_q == GAIN_0DB)
    else $error("gain not 0dB while disabled");
  a_start_0db: assert property
    ($rose(en) |=> gain_q == GAIN_0DB && st_q == ST_RECOVER)
    else $error("enable did not start at 0dB");
  a_cut_amount: assert property (cut && en |=>
    gain_q == (($past(gain_q) < 6'($past(att_steps))) ? GAIN_MIN :
      $past(gain_q) - 6'($past(att_steps))))
    else $error("wrong limiter cut");
  a_cut_now: assert property
    (en && st_q == ST_RECOVER && over |=> st_q == ST_LIMIT)
    else $error("limiter did not take over");
  a_cap_ref: assert property
    (rec_step && en && gain_q <= ref_lvl |=> gain_q <= ref_lvl)
    else $error("recovery above reference");
  a_rec_size: assert property (rec_step && en && gain_q < ref_lvl |=>
    gain_q - $past(gain_q) <= 6'($past(rec_steps)))
    else $error("recovery step too large");
  a_no_ramp: assert property (en && ramp_dis && st_q != ST_OFF &&
    gain_q != gain_out_q |=> gain_out_q == $past(gain_q))
    else $error("increase not immediate");
  a_band_hold: assert property
    (en && st_q == ST_RECOVER && in_band |=> wait_t.count == '0)
    else $error("band did not reset wait");
  a_mute_out: assert property
    (ctrl_q[CTRL_MUTE] ##1 ctrl_q[CTRL_MUTE] |-> line_out_muted)
    else $error("mute not applied");
  a_buf_power: assert property (##1 input_buf_power ==
    $past(ctrl_q[CTRL_LOPWR] | ctrl_q[CTRL_HPLPW] |
          ctrl_q[CTRL_HPRPW]))
    else $error("input buffer power wrong");
  a_bad_rate: assert property
    (scale == '0 |-> !wait_t.done && !lim_t.done)
    else $error("timer active at bad rate");

  // Raises may lag the target, but climb one code per step only
  sequence s_ramping;
    en && !ramp_dis && st_q != ST_OFF && gain_q > gain_out_q;
  endsequence

  a_ramp_one: assert property
    (s_ramping |=> gain_out_q <= $past(gain_out_q) + 6'd1)
    else $error("ramp raised more than one code");
  a_lim_wait: assert property
    (en && st_q == ST_LIMIT && !lim_t.done |=> $stable(gain_q))
    else $error("gain cut inside limiter period");
  a_no_wrap: assert property
    (cut && en |=> gain_q <= $past(gain_q))
    else $error("limiter cut wrapped gain");
  a_bad_hold: assert property
    (en && st_q != ST_OFF && scale == '0 && !over |=> $stable(gain_q))
    else $error("gain moved at bad rate");
  a_att_copy: assert property
    (##1 line_out_atten == $past(vol_q[VOL_ATT +: 4]))
    else $error("attenuation code not applied");
  a_bass_copy: assert property
    (##1 bass_boost_sel == $past(ctrl_q[CTRL_BASS +: 2]))
    else $error("boost code not applied");
  a_unmute: assert property
    (!ctrl_q[CTRL_MUTE] ##1 !ctrl_q[CTRL_MUTE] |-> !line_out_muted)
    else $error("mute not released");
endmodule : lineout_level_ctrl

/* common/lineout_alc_pkg.sv */
package lineout_alc_pkg;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CFG  = 8'h04;
  localparam logic [7:0] ADDR_VOL  = 8'h08;
  localparam logic [7:0] ADDR_STAT = 8'h0c;

  localparam int CTRL_EN    = 0;
  localparam int CTRL_LOPWR = 1;
  localparam int CTRL_HPLPW = 2;
  localparam int CTRL_HPRPW = 3;
  localparam int CTRL_MUTE  = 4;
  localparam int CTRL_RAMPD = 5;
  localparam int CTRL_RATE  = 8;
  localparam int CTRL_BASS  = 12;
  localparam logic [31:0] CTRL_MASK = 32'h0000_3f3f;
  localparam logic [31:0] CTRL_RST  = 32'h0000_0010;

  localparam int CFG_THR   = 0;
  localparam int CFG_ATT   = 1;
  localparam int CFG_LIMP  = 3;
  localparam int CFG_WAIT  = 5;
  localparam int CFG_RGAIN = 7;
  localparam int CFG_PTS   = 8;
  localparam int CFG_REF   = 16;
  localparam logic [31:0] CFG_MASK = 32'h003f_03ff;
  localparam logic [31:0] CFG_RST  = 32'h003c_0000;

  localparam int VOL_ATT = 0;
  localparam logic [31:0] VOL_MASK = 32'h0000_000f;
  localparam logic [31:0] VOL_RST  = 32'h0000_0000;

  localparam int STAT_TGT = 8;
  localparam int STAT_ST  = 16;
  localparam int STAT_BAD = 20;

  localparam logic [5:0] GAIN_0DB = 6'h18;
  localparam logic [5:0] GAIN_MIN = 6'h00;

  // Levels are signed, in 0.5 dBV units
  localparam logic signed [7:0] LIM_HI  = -8'sd15;
  localparam logic signed [7:0] BAND_HI = -8'sd19;
  localparam logic signed [7:0] LIM_LO  = -8'sd23;
  localparam logic signed [7:0] BAND_LO = -8'sd27;

  // Periods in 1/fs at rate code 0000
  localparam logic [18:0] LIM_BASE  = 19'd6;
  localparam logic [18:0] WAIT_BASE = 19'd768;
  localparam logic [18:0] WAIT_LONG = 19'd24576;
  localparam logic [18:0] RAMP_BASE = 19'd768;
  localparam logic [18:0] SCALE_DEN = 19'd6;

  typedef enum logic [1:0] {ST_OFF, ST_LIMIT, ST_RECOVER} alc_state_t;

  // Rate scale in twelfths of the 0000 period; 0 marks unsupported
  function automatic logic [3:0] rate_scale(input logic [3:0] rc);
    unique case (rc)
      4'h0, 4'h2: rate_scale = 4'hc;
      4'h1:       rate_scale = 4'h8;
      4'h8, 4'ha: rate_scale = 4'h6;
      4'h9:       rate_scale = 4'h4;
      4'hc, 4'he: rate_scale = 4'h3;
      4'hd:       rate_scale = 4'h2;
      default:    rate_scale = 4'h0;
    endcase
  endfunction : rate_scale
endpackage : lineout_alc_pkg

/* common/period_timer_if.sv */
`timescale 1ns/1ns
interface period_timer_if;
  logic        tick;
  logic        clear;
  logic [16:0] target;
  logic [16:0] count;
  logic        done;
  modport ctrl (output tick, output clear, output target,
                input count, input done);
  modport tmr  (input tick, input clear, input target,
                output count, output done);
endinterface : period_timer_if

/* rtl/period_timer.sv */
`timescale 1ns/1ns
module period_timer
  import lineout_alc_pkg::*;
(
  input wire logic     sys_clk, // 250 MHz clock
  input wire logic     nrst,    // Sync reset, low
  period_timer_if.tmr  t        // Timer control
);
  localparam logic [16:0] HALF_STEP = 17'd2;

  // Counts half sample periods so 1.5/fs targets fit
  always_ff @(posedge sys_clk) begin
    if (!nrst || t.clear) begin
      t.count <= '0;
    end else if (t.tick && t.target != '0 && !t.done) begin
      t.count <= t.count + HALF_STEP;
    end
  end

  // A zero target (unsupported rate) never completes
  assign t.done = (t.target != '0) && (t.count >= t.target);

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  a_clear_zero: assert property (t.clear |=> t.count == '0)
    else $error("timer not cleared");
  a_tick_only: assert property
    (!t.tick && !t.clear |=> $stable(t.count))
    else $error("timer moved without fs tick");
endmodule : period_timer

/* test/tb_top.sv */
`timescale 1ns/1ns
module tb_top;
  import lineout_alc_pkg::*;

  typedef struct {
    logic [2:0]        cfg;
    logic signed [7:0] l;
    logic signed [7:0] r;
    logic [5:0]        g;
  } row_t;

  logic              sys_clk = 1'b0;
  logic              nrst    = 1'b0;
  logic              psel    = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite  = 1'b0;
  logic [7:0]        paddr   = 8'h00;
  logic [31:0]       pwdata  = 32'h0;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic              fs_tick = 1'b0;
  logic signed [7:0] lv_l    = -8'sd60;
  logic signed [7:0] lv_r    = -8'sd60;
  logic [5:0]        alc_gain;
  logic [3:0]        line_out_atten;
  logic              line_out_muted;
  logic [1:0]        bass_boost_sel;
  logic              input_buf_power;
  logic [31:0]       rdv;
  logic              errv;
  int                n_fail = 0;
  int                checks_done = 0;
  int                cyc = 0;
  row_t              rows [7];

  always #2 sys_clk = ~sys_clk;

  lineout_level_ctrl uut (
    .sys_clk        (sys_clk),
    .nrst           (nrst),
    .psel           (psel),
    .penable        (penable),
    .pwrite         (pwrite),
    .paddr          (paddr),
    .pwdata         (pwdata),
    .prdata         (prdata),
    .pready         (pready),
    .pslverr        (pslverr),
    .fs_tick        (fs_tick),
    .left_level     (lv_l),
    .right_level    (lv_r),
    .alc_gain       (alc_gain),
    .line_out_atten (line_out_atten),
    .line_out_muted (line_out_muted),
    .bass_boost_sel (bass_boost_sel),
    .input_buf_power(input_buf_power)
  );

  task automatic end_sim();
    $display("checks=%0d fails=%0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_sim

  // Generous ceiling: the full sequence needs about 4200 cycles
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      end_sim();
    end
  end

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t reg got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_reg

  task automatic chk_out(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t out got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_out

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge sys_clk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rdv = prdata;
    errv = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic settle();
    repeat (2) @(posedge sys_clk);
    #1;
  endtask : settle

  task automatic ticks(input int n, input logic signed [7:0] l,
                       input logic signed [7:0] r);
    for (int i = 0; i < n; i++) begin
      @(posedge sys_clk);
      fs_tick <= 1'b1;
      lv_l    <= l;
      lv_r    <= r;
      @(posedge sys_clk);
      fs_tick <= 1'b0;
    end
    settle();
  endtask : ticks

  // Settings only change while the controller is disabled
  task automatic setup(input logic [2:0] cfg, input logic [31:0] ctrl);
    apb(1'b1, ADDR_CTRL, 32'h0);
    apb(1'b1, ADDR_CFG, CFG_RST | {29'h0, cfg});
    apb(1'b1, ADDR_CTRL, ctrl);
    settle();
  endtask : setup

  initial begin
    rows = '{'{3'h0, -8'sd10, -8'sd40, 6'h17},
             '{3'h2, -8'sd40, -8'sd10, 6'h16},
             '{3'h4, -8'sd15, -8'sd40, 6'h15},
             '{3'h6, -8'sd10, -8'sd10, 6'h14},
             '{3'h0, -8'sd16, -8'sd40, 6'h18},
             '{3'h1, -8'sd23, -8'sd40, 6'h17},
             '{3'h1, -8'sd24, -8'sd24, 6'h18}};
    repeat (12) @(posedge sys_clk);
    nrst <= 1'b1;
    #1;
    chk_out({2'h0, alc_gain}, 8'h18);
    chk_out({7'h0, line_out_muted}, 8'h01);
    chk_out({6'h0, bass_boost_sel}, 8'h00);
    chk_out({7'h0, input_buf_power}, 8'h00);
    chk_out({4'h0, line_out_atten}, 8'h00);
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk_reg(rdv, CTRL_RST);
    apb(1'b0, ADDR_CFG, 32'h0);
    chk_reg(rdv, CFG_RST);
    apb(1'b0, ADDR_VOL, 32'h0);
    chk_reg(rdv, VOL_RST);
    apb(1'b1, 8'h10, 32'hffff_ffff);
    chk_reg({31'h0, errv}, 32'h1);
    apb(1'b0, 8'h10, 32'h0);
    chk_reg({31'h0, errv}, 32'h1);
    chk_reg(rdv, 32'h0);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, ADDR_CTRL, (32'(i) << CTRL_BASS) | ((32'h1 << i) & 32'he));
      settle();
      chk_out({6'h0, bass_boost_sel}, 8'(i));
      chk_out({7'h0, input_buf_power}, {7'h0, i != 0});
      chk_out({7'h0, line_out_muted}, 8'h00);
    end
    apb(1'b1, ADDR_VOL, 32'hf);
    settle();
    chk_out({4'h0, line_out_atten}, 8'h0f);
    apb(1'b1, ADDR_CTRL, 32'h0000_0010);
    settle();
    chk_out({7'h0, line_out_muted}, 8'h01);
    foreach (rows[k]) begin
      setup(rows[k].cfg, 32'h1);
      chk_out({2'h0, alc_gain}, 8'h18);
      ticks(1, rows[k].l, rows[k].r);
      chk_out({2'h0, alc_gain}, {2'h0, rows[k].g});
    end
    setup(3'h6, 32'h0);
    ticks(3, -8'sd10, -8'sd10);
    chk_out({2'h0, alc_gain}, 8'h18);
    apb(1'b1, ADDR_CTRL, 32'h1);
    ticks(1, -8'sd10, -8'sd10);
    ticks(1, -8'sd10, -8'sd10);
    chk_out({2'h0, alc_gain}, 8'h14);
    ticks(100, -8'sd10, -8'sd10);
    chk_out({2'h0, alc_gain}, 8'h00);
    setup(3'h0, 32'h21);
    ticks(1, -8'sd10, -8'sd10);
    ticks(800, -8'sd17, -8'sd17);
    chk_out({2'h0, alc_gain}, 8'h17);
    ticks(760, -8'sd40, -8'sd40);
    chk_out({2'h0, alc_gain}, 8'h17);
    ticks(40, -8'sd40, -8'sd40);
    chk_out({2'h0, alc_gain}, 8'h18);
    apb(1'b0, ADDR_STAT, 32'h0);
    chk_reg(rdv & 32'h3f, 32'h18);
    ticks(1, -8'sd10, -8'sd10);
    chk_out({2'h0, alc_gain}, 8'h17);
    // Rate code d shortens wait and ramp to 128 ticks, limit to 1
    setup(3'h0, 32'h0000_0d01);
    ticks(1, -8'sd10, -8'sd10);
    chk_out({2'h0, alc_gain}, 8'h17);
    ticks(130, -8'sd40, -8'sd40);
    chk_out({2'h0, alc_gain}, 8'h17);
    apb(1'b0, ADDR_STAT, 32'h0);
    chk_reg((rdv >> STAT_TGT) & 32'h3f, 32'h18);
    chk_reg(rdv & 32'h3f, 32'h17);
    ticks(120, -8'sd40, -8'sd40);
    chk_out({2'h0, alc_gain}, 8'h17);
    ticks(10, -8'sd40, -8'sd40);
    chk_out({2'h0, alc_gain}, 8'h18);
    setup(3'h0, 32'h0000_0301);
    ticks(1, -8'sd10, -8'sd10);
    ticks(3, -8'sd10, -8'sd10);
    chk_out({2'h0, alc_gain}, 8'h17);
    apb(1'b0, ADDR_STAT, 32'h0);
    chk_reg((rdv >> STAT_BAD) & 32'h1, 32'h1);
    end_sim();
  end
endmodule : tb_top
